// *** inc/ibcs_defines.svh ***
/*
 * Timing counts and reset values for the instruction bus cycle sequencer.
 * Assumes inclusion by bare name from the sequencer source.
 */
`ifndef IBCS_DEFINES_SVH
`define IBCS_DEFINES_SVH

// ----------------------------------------
// Machine cycle lengths in clock states
// ----------------------------------------
`define IBCS_BUS_STATES 2'h3
`define IBCS_IDLE_STATES 2'h1
`define IBCS_LONG_IDLE_STATES 2'h3

// ----------------------------------------
// Fixed address parts and reset values
// ----------------------------------------
`define IBCS_PAGE0_HIGH 8'h00
`define IBCS_ADDR_RST 16'h0000
`define IBCS_BYTE_RST 8'h00
`define IBCS_STEP_RST 3'h0
`define IBCS_TCNT_RST 2'h0
`define IBCS_STEP_ONE 3'h1
`define IBCS_TCNT_ONE 2'h1
`define IBCS_ADDR_ONE 16'h0001
`define IBCS_ADDR_TWO 16'h0002

`endif

// *** inc/ibcs_pkg.sv ***
/*
 * Types for the instruction bus cycle sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ibcs_pkg;

  // ----------------------------------------
  // Instruction groups
  // ----------------------------------------
  typedef enum logic [4:0] {
    GRP_SIMPLE = 5'h00,
    GRP_CALL_COND = 5'h01,
    GRP_SEARCH_REPEAT = 5'h02,
    GRP_COUNT_BRANCH = 5'h03,
    GRP_INT_MASK = 5'h04,
    GRP_INT_UNMASK = 5'h05,
    GRP_XCHG_INDEX_STACK = 5'h06,
    GRP_INDEX_MEM_STEP = 5'h07,
    GRP_INDEX_REG_STEP = 5'h08,
    GRP_PORT_IN_ACC = 5'h09,
    GRP_PAGE0_PORT_IN = 5'h0A,
    GRP_JUMP_COND = 5'h0B,
    GRP_BRANCH_COND = 5'h0C,
    GRP_INDEX_LOAD = 5'h0D,
    GRP_INDEX_STORE = 5'h0E,
    GRP_INDEX_STORE_IMM = 5'h0F,
    GRP_HALT = 5'h10
  } ibcs_group_t;

  // ----------------------------------------
  // Machine cycle kinds
  // ----------------------------------------
  typedef enum logic [2:0] {
    K_FETCH1 = 3'h0,
    K_FETCH2 = 3'h1,
    K_OPND = 3'h2,
    K_MEM_RD = 3'h3,
    K_MEM_WR = 3'h4,
    K_IO_RD = 3'h5,
    K_IDLE = 3'h6,
    K_IDLE_LONG = 3'h7
  } ibcs_kind_t;

  typedef enum logic [3:0] {
    A_NONE = 4'h0,
    A_FETCH = 4'h1,
    A_STACK = 4'h2,
    A_STACK_P1 = 4'h3,
    A_STACK_M1 = 4'h4,
    A_STACK_M2 = 4'h5,
    A_POINTER = 4'h6,
    A_INDEX_DISP = 4'h7,
    A_PORT_ACC = 4'h8,
    A_PORT_ZERO = 4'h9
  } ibcs_asrc_t;

  typedef enum logic [2:0] {
    D_NONE = 3'h0,
    D_RET_HIGH = 3'h1,
    D_RET_LOW = 3'h2,
    D_INDEX_HIGH = 3'h3,
    D_INDEX_LOW = 3'h4,
    D_IMM = 3'h5,
    D_ALU = 3'h6
  } ibcs_dsrc_t;

  typedef struct packed {
    ibcs_kind_t kind;
    ibcs_asrc_t asrc;
    ibcs_dsrc_t dsrc;
    logic last;
  } ibcs_cycle_t;

  typedef enum logic [2:0] {
    S_WAIT = 3'b001,
    S_RUN = 3'b010,
    S_HALT = 3'b100
  } ibcs_state_t;

endpackage

// *** src/ibcs_sequencer.sv ***
/*
 * Machine cycle sequencer: per instruction group, orders fetch, operand,
 * idle, memory and port cycles and drives address, data and strobes.
 * Assumes decoded group, condition and register values from the datapath,
 * stable from start_i until done_o.
 */
`include "ibcs_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module ibcs_sequencer #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic [4:0] group_i,
  input wire logic cond_true_i,
  input wire logic loop_nonzero_i,
  input wire logic count_zero_i,
  input wire logic wake_i,
  input wire logic [ADDR_W-1:0] pc_i,
  input wire logic [ADDR_W-1:0] stack_pointer_i,
  input wire logic [ADDR_W-1:0] pointer_pair_main_i,
  input wire logic [ADDR_W-1:0] index_reg_i,
  input wire logic [DATA_W-1:0] acc_i,
  input wire logic [DATA_W-1:0] alu_data_i,
  input wire logic [DATA_W-1:0] data_i,
  input wire logic bus_req_i,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic storage_access_strobe_n_o,
  output logic port_access_strobe_n_o,
  output logic opcode_load_strobe_n_o,
  output logic halt_n_o,
  output logic lead_fetch_flag_o,
  output logic done_o,
  output logic search_repeat_o,
  output logic int_sample_o,
  output logic bus_grant_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  ibcs_pkg::ibcs_state_t state_r;
  ibcs_pkg::ibcs_group_t grp_r;
  ibcs_pkg::ibcs_cycle_t cur;
  logic [2:0] step_r;
  logic [1:0] tcnt_r;
  logic [1:0] len;
  logic cyc_end;
  logic cond_r;
  logic loop_nz_r;
  logic term_r;
  logic opnd_sel_r;
  logic bus_lock_r;
  logic [ADDR_W-1:0] fetch_ptr_r;
  logic [DATA_W-1:0] byte0_r;
  logic [DATA_W-1:0] byte1_r;
  logic [ADDR_W-1:0] index_disp;

  function automatic ibcs_pkg::ibcs_cycle_t mc(ibcs_pkg::ibcs_kind_t k,
                                               ibcs_pkg::ibcs_asrc_t a,
                                               ibcs_pkg::ibcs_dsrc_t d,
                                               logic l);
    mc = '{kind: k, asrc: a, dsrc: d, last: l};
  endfunction

  // ----------------------------------------
  // Cycle table per group and step
  // ----------------------------------------
  always_comb begin
    ibcs_pkg::ibcs_cycle_t f1;
    ibcs_pkg::ibcs_cycle_t f2;
    ibcs_pkg::ibcs_cycle_t op;
    ibcs_pkg::ibcs_cycle_t idl;
    f1 = mc(ibcs_pkg::K_FETCH1, ibcs_pkg::A_FETCH, ibcs_pkg::D_NONE, 1'b0);
    f2 = mc(ibcs_pkg::K_FETCH2, ibcs_pkg::A_FETCH, ibcs_pkg::D_NONE, 1'b0);
    op = mc(ibcs_pkg::K_OPND, ibcs_pkg::A_FETCH, ibcs_pkg::D_NONE, 1'b0);
    idl = mc(ibcs_pkg::K_IDLE, ibcs_pkg::A_NONE, ibcs_pkg::D_NONE, 1'b0);
    cur = f1;
    case (grp_r)
      ibcs_pkg::GRP_CALL_COND: begin
        case (step_r)
          3'h0: cur = f1;
          3'h1: cur = mc(ibcs_pkg::K_OPND, ibcs_pkg::A_FETCH, ibcs_pkg::D_NONE, !cond_r);
          3'h2: cur = op;
          3'h3: cur = idl;
          3'h4: cur = mc(ibcs_pkg::K_MEM_WR, ibcs_pkg::A_STACK_M1, ibcs_pkg::D_RET_HIGH, 1'b0);
          default: cur = mc(ibcs_pkg::K_MEM_WR, ibcs_pkg::A_STACK_M2, ibcs_pkg::D_RET_LOW, 1'b1);
        endcase
      end
      // Search repeat, long or short tail
      ibcs_pkg::GRP_SEARCH_REPEAT: begin
        case (step_r)
          3'h0: cur = f1;
          3'h1: cur = f2;
          3'h2: cur = mc(ibcs_pkg::K_MEM_RD, ibcs_pkg::A_POINTER, ibcs_pkg::D_NONE, 1'b0);
          3'h3: cur = idl;
          3'h4: cur = idl;
          default: cur = mc(term_r ? ibcs_pkg::K_IDLE : ibcs_pkg::K_IDLE_LONG,
                            ibcs_pkg::A_NONE, ibcs_pkg::D_NONE, 1'b1);
        endcase
      end
      ibcs_pkg::GRP_COUNT_BRANCH: begin
        case (step_r)
          3'h0: cur = f1;
          3'h1: cur = idl;
          3'h2: cur = mc(ibcs_pkg::K_OPND, ibcs_pkg::A_FETCH, ibcs_pkg::D_NONE, !loop_nz_r);
          3'h3: cur = idl;
          default: cur = mc(ibcs_pkg::K_IDLE, ibcs_pkg::A_NONE, ibcs_pkg::D_NONE, 1'b1);
        endcase
      end
      ibcs_pkg::GRP_XCHG_INDEX_STACK: begin
        case (step_r)
          3'h0: cur = f1;
          3'h1: cur = f2;
          3'h2: cur = mc(ibcs_pkg::K_MEM_RD, ibcs_pkg::A_STACK, ibcs_pkg::D_NONE, 1'b0);
          3'h3: cur = mc(ibcs_pkg::K_MEM_RD, ibcs_pkg::A_STACK_P1, ibcs_pkg::D_NONE, 1'b0);
          3'h4: cur = idl;
          3'h5: cur = mc(ibcs_pkg::K_MEM_WR, ibcs_pkg::A_STACK_P1, ibcs_pkg::D_INDEX_HIGH, 1'b0);
          default: cur = mc(ibcs_pkg::K_MEM_WR, ibcs_pkg::A_STACK, ibcs_pkg::D_INDEX_LOW, 1'b1);
        endcase
      end
      ibcs_pkg::GRP_INDEX_MEM_STEP: begin
        case (step_r)
          3'h0: cur = f1;
          3'h1: cur = f2;
          3'h2: cur = op;
          3'h3: cur = idl;
          3'h4: cur = idl;
          3'h5: cur = mc(ibcs_pkg::K_MEM_RD, ibcs_pkg::A_INDEX_DISP, ibcs_pkg::D_NONE, 1'b0);
          3'h6: cur = idl;
          default: cur = mc(ibcs_pkg::K_MEM_WR, ibcs_pkg::A_INDEX_DISP, ibcs_pkg::D_ALU, 1'b1);
        endcase
      end
      ibcs_pkg::GRP_INDEX_REG_STEP: begin
        case (step_r)
          3'h0: cur = f1;
          3'h1: cur = f2;
          default: cur = mc(ibcs_pkg::K_IDLE, ibcs_pkg::A_NONE, ibcs_pkg::D_NONE, 1'b1);
        endcase
      end
      ibcs_pkg::GRP_PORT_IN_ACC: begin
        case (step_r)
          3'h0: cur = f1;
          3'h1: cur = op;
          default: cur = mc(ibcs_pkg::K_IO_RD, ibcs_pkg::A_PORT_ACC, ibcs_pkg::D_NONE, 1'b1);
        endcase
      end
      ibcs_pkg::GRP_PAGE0_PORT_IN: begin
        case (step_r)
          3'h0: cur = f1;
          3'h1: cur = f2;
          3'h2: cur = op;
          default: cur = mc(ibcs_pkg::K_IO_RD, ibcs_pkg::A_PORT_ZERO, ibcs_pkg::D_NONE, 1'b1);
        endcase
      end
      ibcs_pkg::GRP_JUMP_COND: begin
        case (step_r)
          3'h0: cur = f1;
          3'h1: cur = mc(ibcs_pkg::K_OPND, ibcs_pkg::A_FETCH, ibcs_pkg::D_NONE, !cond_r);
          default: cur = mc(ibcs_pkg::K_OPND, ibcs_pkg::A_FETCH, ibcs_pkg::D_NONE, 1'b1);
        endcase
      end
      ibcs_pkg::GRP_BRANCH_COND: begin
        case (step_r)
          3'h0: cur = f1;
          3'h1: cur = mc(ibcs_pkg::K_OPND, ibcs_pkg::A_FETCH, ibcs_pkg::D_NONE, !cond_r);
          3'h2: cur = idl;
          default: cur = mc(ibcs_pkg::K_IDLE, ibcs_pkg::A_NONE, ibcs_pkg::D_NONE, 1'b1);
        endcase
      end
      ibcs_pkg::GRP_INDEX_LOAD: begin
        case (step_r)
          3'h0: cur = f1;
          3'h1: cur = f2;
          3'h2: cur = op;
          3'h3: cur = idl;
          3'h4: cur = idl;
          default: cur = mc(ibcs_pkg::K_MEM_RD, ibcs_pkg::A_INDEX_DISP, ibcs_pkg::D_NONE, 1'b1);
        endcase
      end
      ibcs_pkg::GRP_INDEX_STORE: begin
        case (step_r)
          3'h0: cur = f1;
          3'h1: cur = f2;
          3'h2: cur = op;
          3'h3: cur = idl;
          3'h4: cur = idl;
          3'h5: cur = idl;
          default: cur = mc(ibcs_pkg::K_MEM_WR, ibcs_pkg::A_INDEX_DISP, ibcs_pkg::D_ALU, 1'b1);
        endcase
      end
      ibcs_pkg::GRP_INDEX_STORE_IMM: begin
        case (step_r)
          3'h0: cur = f1;
          3'h1: cur = f2;
          3'h2: cur = op;
          3'h3: cur = op;
          default: cur = mc(ibcs_pkg::K_MEM_WR, ibcs_pkg::A_INDEX_DISP, ibcs_pkg::D_IMM, 1'b1);
        endcase
      end
      default: cur = mc(ibcs_pkg::K_FETCH1, ibcs_pkg::A_FETCH, ibcs_pkg::D_NONE, 1'b1);
    endcase
  end

  always_comb begin
    case (cur.kind)
      ibcs_pkg::K_IDLE: len = `IBCS_IDLE_STATES;
      ibcs_pkg::K_IDLE_LONG: len = `IBCS_LONG_IDLE_STATES;
      default: len = `IBCS_BUS_STATES;
    endcase
  end

  assign cyc_end = (state_r == ibcs_pkg::S_RUN) && (tcnt_r == len - `IBCS_TCNT_ONE);
  assign index_disp = index_reg_i + {{(ADDR_W-DATA_W){byte0_r[DATA_W-1]}}, byte0_r};

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= ibcs_pkg::S_WAIT;
      grp_r <= ibcs_pkg::GRP_SIMPLE;
      step_r <= `IBCS_STEP_RST;
      tcnt_r <= `IBCS_TCNT_RST;
      cond_r <= 1'b0;
      loop_nz_r <= 1'b0;
    end else begin
      case (state_r)
        ibcs_pkg::S_WAIT: begin
          if (start_i) begin
            state_r <= ibcs_pkg::S_RUN;
            grp_r <= ibcs_pkg::ibcs_group_t'(group_i);
            step_r <= `IBCS_STEP_RST;
            tcnt_r <= `IBCS_TCNT_RST;
            cond_r <= cond_true_i;
            loop_nz_r <= loop_nonzero_i;
          end
        end
        ibcs_pkg::S_RUN: begin
          if (cyc_end) begin
            tcnt_r <= `IBCS_TCNT_RST;
            step_r <= step_r + `IBCS_STEP_ONE;
            if (cur.last) begin
              state_r <= (grp_r == ibcs_pkg::GRP_HALT) ? ibcs_pkg::S_HALT : ibcs_pkg::S_WAIT;
            end
          end else begin
            tcnt_r <= tcnt_r + `IBCS_TCNT_ONE;
          end
        end
        ibcs_pkg::S_HALT: begin
          if (wake_i) begin
            state_r <= ibcs_pkg::S_WAIT;
          end
        end
        default: state_r <= ibcs_pkg::S_WAIT;
      endcase
    end
  end

  // ----------------------------------------
  // Fetch pointer and captured bytes
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fetch_ptr_r <= `IBCS_ADDR_RST;
      byte0_r <= `IBCS_BYTE_RST;
      byte1_r <= `IBCS_BYTE_RST;
      opnd_sel_r <= 1'b0;
      term_r <= 1'b0;
    end else if (state_r == ibcs_pkg::S_WAIT && start_i) begin
      fetch_ptr_r <= pc_i;
      opnd_sel_r <= 1'b0;
      term_r <= 1'b0;
    end else if (cyc_end) begin
      if (cur.kind == ibcs_pkg::K_FETCH1 || cur.kind == ibcs_pkg::K_FETCH2 ||
          cur.kind == ibcs_pkg::K_OPND) begin
        fetch_ptr_r <= fetch_ptr_r + `IBCS_ADDR_ONE;
      end
      if (cur.kind == ibcs_pkg::K_OPND) begin
        opnd_sel_r <= 1'b1;
        if (opnd_sel_r) begin
          byte1_r <= data_i;
        end else begin
          byte0_r <= data_i;
        end
      end
      // End on zero count or match
      if (cur.kind == ibcs_pkg::K_MEM_RD && grp_r == ibcs_pkg::GRP_SEARCH_REPEAT) begin
        term_r <= count_zero_i || (acc_i == data_i);
      end
    end
  end

  // ----------------------------------------
  // Bus outputs, registered from the current cycle
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_o <= `IBCS_ADDR_RST;
      data_o <= `IBCS_BYTE_RST;
      data_oe_o <= 1'b0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      storage_access_strobe_n_o <= 1'b1;
      port_access_strobe_n_o <= 1'b1;
      opcode_load_strobe_n_o <= 1'b1;
      halt_n_o <= 1'b1;
      lead_fetch_flag_o <= 1'b1;
    end else if (state_r == ibcs_pkg::S_HALT) begin
      addr_o <= fetch_ptr_r;
      data_oe_o <= 1'b0;
      rd_n_o <= 1'b0;
      wr_n_o <= 1'b1;
      storage_access_strobe_n_o <= 1'b0;
      port_access_strobe_n_o <= 1'b1;
      opcode_load_strobe_n_o <= 1'b0;
      halt_n_o <= 1'b0;
      lead_fetch_flag_o <= 1'b0;
    end else if (state_r == ibcs_pkg::S_RUN) begin
      halt_n_o <= 1'b1;
      case (cur.asrc)
        ibcs_pkg::A_FETCH: addr_o <= fetch_ptr_r;
        ibcs_pkg::A_STACK: addr_o <= stack_pointer_i;
        ibcs_pkg::A_STACK_P1: addr_o <= stack_pointer_i + `IBCS_ADDR_ONE;
        ibcs_pkg::A_STACK_M1: addr_o <= stack_pointer_i - `IBCS_ADDR_ONE;
        ibcs_pkg::A_STACK_M2: addr_o <= stack_pointer_i - `IBCS_ADDR_TWO;
        ibcs_pkg::A_POINTER: addr_o <= pointer_pair_main_i;
        ibcs_pkg::A_INDEX_DISP: addr_o <= index_disp;
        ibcs_pkg::A_PORT_ACC: addr_o <= {acc_i, byte0_r};
        ibcs_pkg::A_PORT_ZERO: addr_o <= {`IBCS_PAGE0_HIGH, byte0_r};
        default: addr_o <= addr_o;
      endcase
      case (cur.dsrc)
        ibcs_pkg::D_RET_HIGH: data_o <= fetch_ptr_r[ADDR_W-1:DATA_W];
        ibcs_pkg::D_RET_LOW: data_o <= fetch_ptr_r[DATA_W-1:0];
        ibcs_pkg::D_INDEX_HIGH: data_o <= index_reg_i[ADDR_W-1:DATA_W];
        ibcs_pkg::D_INDEX_LOW: data_o <= index_reg_i[DATA_W-1:0];
        ibcs_pkg::D_IMM: data_o <= byte1_r;
        ibcs_pkg::D_ALU: data_o <= alu_data_i;
        default: data_o <= data_o;
      endcase
      data_oe_o <= (cur.kind == ibcs_pkg::K_MEM_WR);
      wr_n_o <= (cur.kind != ibcs_pkg::K_MEM_WR);
      rd_n_o <= (cur.kind == ibcs_pkg::K_MEM_WR) || (cur.kind == ibcs_pkg::K_IDLE) ||
                (cur.kind == ibcs_pkg::K_IDLE_LONG);
      storage_access_strobe_n_o <= (cur.kind == ibcs_pkg::K_IO_RD) ||
                                   (cur.kind == ibcs_pkg::K_IDLE) ||
                                   (cur.kind == ibcs_pkg::K_IDLE_LONG);
      port_access_strobe_n_o <= (cur.kind != ibcs_pkg::K_IO_RD);
      opcode_load_strobe_n_o <= !(cur.kind == ibcs_pkg::K_FETCH1 ||
                                  cur.kind == ibcs_pkg::K_FETCH2);
      lead_fetch_flag_o <= (cur.kind != ibcs_pkg::K_FETCH1);
    end else begin
      data_oe_o <= 1'b0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      storage_access_strobe_n_o <= 1'b1;
      port_access_strobe_n_o <= 1'b1;
      opcode_load_strobe_n_o <= 1'b1;
      halt_n_o <= 1'b1;
      lead_fetch_flag_o <= 1'b1;
    end
  end

  // ----------------------------------------
  // Completion, interrupt sampling, bus release
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_o <= 1'b0;
      search_repeat_o <= 1'b0;
      int_sample_o <= 1'b0;
    end else begin
      done_o <= cyc_end && cur.last;
      search_repeat_o <= cyc_end && cur.last && grp_r == ibcs_pkg::GRP_SEARCH_REPEAT && !term_r;
      // No sampling after mask or unmask
      int_sample_o <= cyc_end && cur.last && grp_r != ibcs_pkg::GRP_INT_MASK &&
                      grp_r != ibcs_pkg::GRP_INT_UNMASK && grp_r != ibcs_pkg::GRP_HALT;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bus_lock_r <= 1'b0;
      bus_grant_o <= 1'b0;
    end else begin
      // Lock from marked idle to completion
      if (cyc_end && grp_r == ibcs_pkg::GRP_COUNT_BRANCH && step_r == `IBCS_STEP_ONE) begin
        bus_lock_r <= 1'b1;
      end else if (cyc_end && cur.last) begin
        bus_lock_r <= 1'b0;
      end
      bus_grant_o <= bus_req_i && !bus_lock_r && state_r != ibcs_pkg::S_RUN;
    end
  end

endmodule

`default_nettype wire

// *** tb/ibcs_mem_model.sv ***
/*
 * Memory and port model answering the sequencer's read cycles.
 * Assumes read data is taken while the read strobe is low.
 */
`timescale 1ns/1ns
`default_nettype none
module ibcs_mem_model (
  input wire logic core_clk_i,
  input wire logic [15:0] addr_i,
  input wire logic rd_n_i,
  output logic [7:0] data_o
);
  // ----------------------------------------
  // Read answer
  // ----------------------------------------
  logic [7:0] junk_r = 8'h3C;
  // Released bus shows a changing pattern, never the last byte
  always_ff @(posedge core_clk_i) begin
    junk_r <= ~junk_r + 8'h01;
  end
  assign data_o = !rd_n_i ? (addr_i[7:0] ^ 8'hA5) : junk_r;
endmodule
`default_nettype wire

// *** tb/ibcs_sequencer_asserts.sv ***
/*
 * Pin-level checker for the bus cycle sequencer.
 * Assumes it is bound to the sequencer top module.
 */
`timescale 1ns/1ns
`default_nettype none
module ibcs_sequencer_asserts (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic [4:0] group_i,
  input wire logic bus_req_i,
  input wire logic data_oe_o,
  input wire logic rd_n_o,
  input wire logic wr_n_o,
  input wire logic storage_access_strobe_n_o,
  input wire logic port_access_strobe_n_o,
  input wire logic opcode_load_strobe_n_o,
  input wire logic halt_n_o,
  input wire logic lead_fetch_flag_o,
  input wire logic done_o,
  input wire logic search_repeat_o,
  input wire logic int_sample_o,
  input wire logic bus_grant_o
);
  // ----------------------------------------
  // Instruction tracking
  // ----------------------------------------
  logic busy_r;
  logic [4:0] grp_r;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_r <= 1'h0;
      grp_r <= 5'h00;
    end else if (start_i && (!busy_r || done_o)) begin
      busy_r <= 1'h1;
      grp_r <= group_i;
    end else if (done_o) begin
      busy_r <= 1'h0;
    end
  end
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence fetch3;
    !opcode_load_strobe_n_o [*3];
  endsequence
  lead_fetch_a:
  assert property (!lead_fetch_flag_o |-> !rd_n_o && !storage_access_strobe_n_o
    && !opcode_load_strobe_n_o && port_access_strobe_n_o) else $error("lead fetch strobes");
  fetch_len_a:
  assert property ($fell(opcode_load_strobe_n_o) |-> fetch3) else $error("short fetch");
  idle_quiet_a:
  assert property (rd_n_o && wr_n_o |-> storage_access_strobe_n_o && port_access_strobe_n_o
    && opcode_load_strobe_n_o && !data_oe_o) else $error("idle not quiet");
  halt_pins_a:
  assert property (!halt_n_o |-> !rd_n_o && !opcode_load_strobe_n_o && !lead_fetch_flag_o
    && wr_n_o) else $error("halt pins");
  write_drive_a:
  assert property (!wr_n_o |-> rd_n_o && data_oe_o && !storage_access_strobe_n_o)
    else $error("write strobes");
  port_read_a:
  assert property (!port_access_strobe_n_o |-> storage_access_strobe_n_o && !rd_n_o)
    else $error("port strobes");
  grant_lock_a:
  assert property (busy_r && $past(busy_r) |-> !bus_grant_o) else $error("grant while busy");
  grant_follow_a:
  assert property (!busy_r && !$past(busy_r) && halt_n_o && $past(halt_n_o)
    |-> bus_grant_o == $past(bus_req_i)) else $error("grant not following request");
  int_sample_a:
  assert property (done_o |-> int_sample_o == !(grp_r == ibcs_pkg::GRP_INT_MASK
    || grp_r == ibcs_pkg::GRP_INT_UNMASK || grp_r == ibcs_pkg::GRP_HALT))
    else $error("interrupt sampling");
  search_pulse_a:
  assert property (search_repeat_o |-> done_o) else $error("repeat without done");
endmodule
bind ibcs_sequencer ibcs_sequencer_asserts chk_u (.*);
`default_nettype wire

// *** tb/tb_top.sv ***
/*
 * Testbench: runs each instruction group but GRP_SIMPLE and compares the bus trace of all but GRP_HALT.
 * Assumes the checker is bound and the memory model answers reads.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic core_clk_i, sys_rst_i, start_i, cond_true_i, loop_nonzero_i, count_zero_i;
  logic wake_i, bus_req_i, data_oe_o, rd_n_o, wr_n_o, storage_access_strobe_n_o;
  logic port_access_strobe_n_o, opcode_load_strobe_n_o, halt_n_o, lead_fetch_flag_o;
  logic done_o, search_repeat_o, int_sample_o, bus_grant_o;
  logic [4:0] group_i;
  logic [15:0] addr_o;
  logic [7:0] acc_i, data_i, data_o;
  int num_errors = 0;
  int num_checks = 0;
  ibcs_sequencer dut_u (.*, .pc_i(16'h1000), .stack_pointer_i(16'h8000),
    .pointer_pair_main_i(16'h4000), .index_reg_i(16'h2000), .alu_data_i(8'hC3));
  ibcs_mem_model mem_u (.core_clk_i, .addr_i(addr_o), .rd_n_i(rd_n_o), .data_o(data_i));
  initial begin
    core_clk_i = 1'h0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Trace letters: F/G fetch, R read, W write, P port read, dot idle
  task automatic run(input logic [4:0] g, input logic c, input logic lz, input logic cz,
    input string exp, input logic [127:0] ea, input logic [63:0] ew, input logic rep,
    input logic smp);
    int n;
    string tr, ch, pch;
    logic [15:0] pa;
    logic [127:0] oa;
    logic [63:0] ow;
    tr = "";
    pch = ".";
    pa = 16'h0000;
    oa = 128'h0;
    ow = 64'h0;
    @(posedge core_clk_i);
    group_i <= g;
    cond_true_i <= c;
    loop_nonzero_i <= lz;
    count_zero_i <= cz;
    start_i <= 1'h1;
    @(posedge core_clk_i);
    start_i <= 1'h0;
    for (n = 0; n < 60; n++) begin
      @(negedge core_clk_i);
      if (opcode_load_strobe_n_o === 1'h0) ch = (lead_fetch_flag_o === 1'h0) ? "F" : "G";
      else if (wr_n_o === 1'h0) ch = "W";
      else if (port_access_strobe_n_o === 1'h0) ch = "P";
      else if (rd_n_o === 1'h0) ch = "R";
      else ch = ".";
      if (ch != "." && (ch != pch || addr_o !== pa)) begin
        oa = {oa[111:0], addr_o};
        if (ch == "W") ow = {ow[55:0], data_o};
      end
      pch = ch;
      pa = addr_o;
      tr = {tr, ch};
      // Done cycle still shows the last machine cycle
      if (done_o === 1'h1) break;
    end
    if (n == 60) begin
      num_errors++;
      wrap_up();
    end
    chk(tr == exp, {"trace ", tr});
    chk(oa === ea, "address order");
    chk(ow === ew, "written data");
    chk(search_repeat_o === rep && int_sample_o === smp, "done flags");
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_branch();
    run(ibcs_pkg::GRP_JUMP_COND, 1'h0, 1'h0, 1'h0, ".FFFRRR",
      {16'h1000, 16'h1001}, 64'h0, 1'h0, 1'h1);
    run(ibcs_pkg::GRP_JUMP_COND, 1'h1, 1'h0, 1'h0, ".FFFRRRRRR",
      {16'h1000, 16'h1001, 16'h1002}, 64'h0, 1'h0, 1'h1);
    run(ibcs_pkg::GRP_BRANCH_COND, 1'h1, 1'h0, 1'h0, ".FFFRRR..",
      {16'h1000, 16'h1001}, 64'h0, 1'h0, 1'h1);
    run(ibcs_pkg::GRP_BRANCH_COND, 1'h0, 1'h0, 1'h0, ".FFFRRR",
      {16'h1000, 16'h1001}, 64'h0, 1'h0, 1'h1);
    run(ibcs_pkg::GRP_CALL_COND, 1'h1, 1'h0, 1'h0, ".FFFRRRRRR.WWWWWW",
      {16'h1000, 16'h1001, 16'h1002, 16'h7FFF, 16'h7FFE}, {8'h10, 8'h03}, 1'h0, 1'h1);
    run(ibcs_pkg::GRP_CALL_COND, 1'h0, 1'h0, 1'h0, ".FFFRRR",
      {16'h1000, 16'h1001}, 64'h0, 1'h0, 1'h1);
  endtask
  task automatic t_search();
    run(ibcs_pkg::GRP_SEARCH_REPEAT, 1'h0, 1'h0, 1'h0, ".FFFGGGRRR.....",
      {16'h1000, 16'h1001, 16'h4000}, 64'h0, 1'h1, 1'h1);
    run(ibcs_pkg::GRP_SEARCH_REPEAT, 1'h0, 1'h0, 1'h1, ".FFFGGGRRR...",
      {16'h1000, 16'h1001, 16'h4000}, 64'h0, 1'h0, 1'h1);
    @(posedge core_clk_i);
    acc_i <= 8'hA5;
    run(ibcs_pkg::GRP_SEARCH_REPEAT, 1'h0, 1'h0, 1'h0, ".FFFGGGRRR...",
      {16'h1000, 16'h1001, 16'h4000}, 64'h0, 1'h0, 1'h1);
    @(posedge core_clk_i);
    acc_i <= 8'h5A;
  endtask
  task automatic t_count_mask();
    run(ibcs_pkg::GRP_COUNT_BRANCH, 1'h0, 1'h0, 1'h0, ".FFF.RRR",
      {16'h1000, 16'h1001}, 64'h0, 1'h0, 1'h1);
    @(posedge core_clk_i);
    bus_req_i <= 1'h1;
    run(ibcs_pkg::GRP_COUNT_BRANCH, 1'h0, 1'h1, 1'h0, ".FFF.RRR..",
      {16'h1000, 16'h1001}, 64'h0, 1'h0, 1'h1);
    @(posedge core_clk_i);
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk(bus_grant_o === 1'h1, "grant after completion");
    @(posedge core_clk_i);
    bus_req_i <= 1'h0;
    run(ibcs_pkg::GRP_INT_MASK, 1'h0, 1'h0, 1'h0, ".FFF",
      {16'h1000}, 64'h0, 1'h0, 1'h0);
    run(ibcs_pkg::GRP_INT_UNMASK, 1'h0, 1'h0, 1'h0, ".FFF",
      {16'h1000}, 64'h0, 1'h0, 1'h0);
  endtask
  task automatic t_index();
    run(ibcs_pkg::GRP_XCHG_INDEX_STACK, 1'h0, 1'h0, 1'h0, ".FFFGGGRRRRRR.WWWWWW",
      {16'h1000, 16'h1001, 16'h8000, 16'h8001, 16'h8001, 16'h8000}, {8'h20, 8'h00},
      1'h0, 1'h1);
    run(ibcs_pkg::GRP_INDEX_MEM_STEP, 1'h0, 1'h0, 1'h0, ".FFFGGGRRR..RRR.WWW",
      {16'h1000, 16'h1001, 16'h1002, 16'h1FA7, 16'h1FA7}, {8'hC3}, 1'h0, 1'h1);
    run(ibcs_pkg::GRP_INDEX_REG_STEP, 1'h0, 1'h0, 1'h0, ".FFFGGG.",
      {16'h1000, 16'h1001}, 64'h0, 1'h0, 1'h1);
    run(ibcs_pkg::GRP_INDEX_LOAD, 1'h0, 1'h0, 1'h0, ".FFFGGGRRR..RRR",
      {16'h1000, 16'h1001, 16'h1002, 16'h1FA7}, 64'h0, 1'h0, 1'h1);
    run(ibcs_pkg::GRP_INDEX_STORE, 1'h0, 1'h0, 1'h0, ".FFFGGGRRR...WWW",
      {16'h1000, 16'h1001, 16'h1002, 16'h1FA7}, {8'hC3}, 1'h0, 1'h1);
    run(ibcs_pkg::GRP_INDEX_STORE_IMM, 1'h0, 1'h0, 1'h0, ".FFFGGGRRRRRRWWW",
      {16'h1000, 16'h1001, 16'h1002, 16'h1003, 16'h1FA7}, {8'hA6}, 1'h0, 1'h1);
  endtask
  task automatic t_port_halt();
    int n;
    run(ibcs_pkg::GRP_PORT_IN_ACC, 1'h0, 1'h0, 1'h0, ".FFFRRRPPP",
      {16'h1000, 16'h1001, 16'h5AA4}, 64'h0, 1'h0, 1'h1);
    run(ibcs_pkg::GRP_PAGE0_PORT_IN, 1'h0, 1'h0, 1'h0, ".FFFGGGRRRPPP",
      {16'h1000, 16'h1001, 16'h1002, 16'h00A7}, 64'h0, 1'h0, 1'h1);
    @(posedge core_clk_i);
    group_i <= ibcs_pkg::GRP_HALT;
    start_i <= 1'h1;
    @(posedge core_clk_i);
    start_i <= 1'h0;
    for (n = 0; n < 20 && halt_n_o !== 1'h0; n++) @(posedge core_clk_i);
    repeat (4) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk(halt_n_o === 1'h0 && addr_o === 16'h1001, "halt address");
    @(posedge core_clk_i);
    wake_i <= 1'h1;
    for (n = 0; n < 20 && halt_n_o !== 1'h1; n++) @(posedge core_clk_i);
    chk(halt_n_o === 1'h1, "halt not left");
    wake_i <= 1'h0;
  endtask
  initial begin
    sys_rst_i = 1'h1;
    start_i = 1'h0;
    group_i = 5'h00;
    cond_true_i = 1'h0;
    loop_nonzero_i = 1'h0;
    count_zero_i = 1'h0;
    wake_i = 1'h0;
    bus_req_i = 1'h0;
    acc_i = 8'h5A;
    repeat (8) @(posedge core_clk_i);
    sys_rst_i <= 1'h0;
    t_branch();
    t_search();
    t_count_mask();
    t_index();
    t_port_halt();
    wrap_up();
  end
endmodule
`default_nettype wire
